// ==== src/etsel_top.sv ====
// Edge trigger selector with pending flags and an AXI4-Lite register slave.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "etsel_defines.svh"
// Contract
// - Falling enable bits at 0x04, lines 0-7,17,18.
// - Other falling register bits reserved, read zero.
// - Lines trigger on edges; sources must be glitch-free.
// - Falling edge during falling-register write: no pending.
// - Both enables set: both edges trigger.
// - Software trigger register at 0x08, resets zero.
// - Rising enable register at 0x00, same layout.
// - Pending set only for unmasked lines.
// - Software trigger one fires, then self-clears.
module etsel_top
   import etsel_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire etsel_pins_t ext_line,
   output logic irq
);
   etsel_edge_t edges;

   etsel_sync u_sync (
      .aclk(aclk),
      .aresetn(aresetn),
      .line_in(ext_line),
      .edges(edges)
   );

   function automatic etsel_word_t merge(etsel_word_t old, etsel_word_t nw, logic [3:0] strb);
      etsel_word_t res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = nw[8*i +: 8];
         end
      end
      return res;
   endfunction

   function automatic logic mapped(logic [7:0] a);
      logic hit;
      hit = (a == `ETSEL_OFF_RISE) || (a == `ETSEL_OFF_FALL) || (a == `ETSEL_OFF_SWT) ||
            (a == `ETSEL_OFF_MASK) || (a == `ETSEL_OFF_PEND);
      return hit;
   endfunction

   // Write channel: address and data are taken in either order and held.
   logic aw_hold_r, w_hold_r, bvalid_r;
   logic aw_hold_nxt, w_hold_nxt, bvalid_nxt;
   etsel_wreq_t wreq_r, wreq_nxt, wr;
   logic [1:0] bresp_r, bresp_nxt;
   logic aw_fire, w_fire, wr_go;
   logic [7:0] wr_off;

   assign awready = ~aw_hold_r & ~bvalid_r;
   assign wready = ~w_hold_r & ~bvalid_r;
   assign aw_fire = awvalid & awready;
   assign w_fire = wvalid & wready;
   assign wr_go = (aw_hold_r | aw_fire) & (w_hold_r | w_fire);

   always_comb begin
      wr.addr = aw_hold_r ? wreq_r.addr : awaddr;
      wr.data = w_hold_r ? wreq_r.data : wdata;
      wr.strb = w_hold_r ? wreq_r.strb : wstrb;
      wr_off = {wr.addr[7:2], 2'h0};
      wreq_nxt = wreq_r;
      if (aw_fire) begin
         wreq_nxt.addr = awaddr;
      end
      if (w_fire) begin
         wreq_nxt.data = wdata;
         wreq_nxt.strb = wstrb;
      end
      aw_hold_nxt = wr_go ? 1'b0 : (aw_hold_r | aw_fire);
      w_hold_nxt = wr_go ? 1'b0 : (w_hold_r | w_fire);
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      if (wr_go) begin
         bvalid_nxt = 1'b1;
         bresp_nxt = mapped(wr_off) ? `ETSEL_RESP_OKAY : `ETSEL_RESP_SLVERR;
      end else if (bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= `ETSEL_RESP_OKAY;
         wreq_r <= '0;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         w_hold_r <= w_hold_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
         wreq_r <= wreq_nxt;
      end
   end

   assign bvalid = bvalid_r;
   assign bresp = bresp_r;

   // Register file and pending logic.
   etsel_word_t rise_en_r, fall_en_r, swt_r, mask_r, pend_r;
   etsel_word_t rise_en_nxt, fall_en_nxt, swt_nxt, mask_nxt, pend_nxt;
   etsel_word_t wr_bits, pend_clr, trig, new_swt;
   logic wr_rise, wr_fall, wr_swt, wr_mask, wr_pend;

   always_comb begin
      wr_rise = wr_go && (wr_off == `ETSEL_OFF_RISE);
      wr_fall = wr_go && (wr_off == `ETSEL_OFF_FALL);
      wr_swt = wr_go && (wr_off == `ETSEL_OFF_SWT);
      wr_mask = wr_go && (wr_off == `ETSEL_OFF_MASK);
      wr_pend = wr_go && (wr_off == `ETSEL_OFF_PEND);
      wr_bits = merge(32'h0000_0000, wr.data, wr.strb) & `ETSEL_LINE_MASK;
      rise_en_nxt = wr_rise ? (merge(rise_en_r, wr.data, wr.strb) & `ETSEL_LINE_MASK) : rise_en_r;
      fall_en_nxt = wr_fall ? (merge(fall_en_r, wr.data, wr.strb) & `ETSEL_LINE_MASK) : fall_en_r;
      mask_nxt = wr_mask ? (merge(mask_r, wr.data, wr.strb) & `ETSEL_LINE_MASK) : mask_r;
      new_swt = wr_swt ? wr_bits : 32'h0000_0000;
      // A written one lives exactly one cycle so a read can still see it.
      swt_nxt = new_swt;
      pend_clr = wr_pend ? wr_bits : 32'h0000_0000;
      // An edge that meets a write to its own select register is dropped, since
      // the enable is changing under it; rising and falling are judged apart.
      trig = (edges.rise & rise_en_r & {32{~wr_rise}})
           | (edges.fall & fall_en_r & {32{~wr_fall}})
           | swt_r;
      // Set beats clear so an edge landing on the acknowledge is kept.
      pend_nxt = (pend_r & ~pend_clr) | (trig & mask_r);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rise_en_r <= `ETSEL_RST_VAL;
         fall_en_r <= `ETSEL_RST_VAL;
         swt_r <= `ETSEL_RST_VAL;
         mask_r <= `ETSEL_RST_VAL;
         pend_r <= `ETSEL_RST_VAL;
      end else begin
         rise_en_r <= rise_en_nxt;
         fall_en_r <= fall_en_nxt;
         swt_r <= swt_nxt;
         mask_r <= mask_nxt;
         pend_r <= pend_nxt;
      end
   end

   // Read channel: one cycle from address to data.
   logic rvalid_r, rvalid_nxt, ar_fire;
   etsel_word_t rdata_r, rdata_nxt, rd_val;
   logic [1:0] rresp_r, rresp_nxt;
   logic [7:0] rd_off;

   assign arready = ~rvalid_r;
   assign ar_fire = arvalid & arready;

   always_comb begin
      rd_off = {araddr[7:2], 2'h0};
      unique case (rd_off)
         `ETSEL_OFF_RISE: rd_val = rise_en_r;
         `ETSEL_OFF_FALL: rd_val = fall_en_r;
         `ETSEL_OFF_SWT: rd_val = swt_r;
         `ETSEL_OFF_MASK: rd_val = mask_r;
         `ETSEL_OFF_PEND: rd_val = pend_r;
         default: rd_val = 32'h0000_0000;
      endcase
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (ar_fire) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_val;
         rresp_nxt = mapped(rd_off) ? `ETSEL_RESP_OKAY : `ETSEL_RESP_SLVERR;
      end else if (rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= `ETSEL_RST_VAL;
         rresp_r <= `ETSEL_RESP_OKAY;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;

   // Masked pending flags are never set, so the gate here is a second guard
   // for lines that are masked after their flag went up.
   logic irq_r, irq_nxt;
   etsel_word_t pend_prev_r;

   always_comb begin
      irq_nxt = |(pend_nxt & mask_nxt);
   end

   // The previous flags are kept only for the checks below, which need to see
   // which flags are new in a cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         irq_r <= 1'b0;
         pend_prev_r <= `ETSEL_RST_VAL;
      end else begin
         irq_r <= irq_nxt;
         pend_prev_r <= pend_r;
      end
   end
   assign irq = irq_r;

   // Checks.
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   etsel_word_t fall_only, pend_new;
   assign fall_only = edges.fall & ~swt_r & ~pend_r;
   assign pend_new = pend_r & ~pend_prev_r;

   sequence s_swt_set;
      swt_r == $past(new_swt);
   endsequence
   sequence s_swt_gone;
      swt_r == 32'h0000_0000;
   endsequence

   chk_fall_write_blk: assert property (wr_fall |=> ((pend_r & $past(fall_only)) == 32'h0000_0000))
      else $error("falling edge during select write set a flag");

   chk_both_edges: assert property ((!wr_fall && |(edges.fall & rise_en_r & fall_en_r & mask_r))
      |=> |(pend_r & $past(edges.fall & rise_en_r & mask_r)))
      else $error("falling edge ignored with both enables set");

   chk_rise_sets: assert property ((!wr_rise && |(edges.rise & rise_en_r & mask_r))
      |=> |(pend_r & $past(edges.rise & mask_r)))
      else $error("enabled rising edge did not set a flag");

   chk_mask_gate: assert property ((pend_new & ~$past(mask_r)) == 32'h0000_0000)
      else $error("flag set on a masked line");

   chk_reserved_zero: assert property
      (((rise_en_r | fall_en_r | swt_r | mask_r | pend_r) & ~`ETSEL_LINE_MASK) == 32'h0000_0000)
      else $error("reserved bit became set");

   chk_fall_read: assert property ((ar_fire && rd_off == `ETSEL_OFF_FALL)
      |=> (rvalid && rdata == $past(fall_en_r)))
      else $error("falling select read back wrong");

   chk_swt_read: assert property ((ar_fire && rd_off == `ETSEL_OFF_SWT)
      |=> (rvalid && rdata == $past(swt_r)))
      else $error("software trigger read back wrong");

   chk_swt_pulse: assert property ((wr_swt && new_swt != 32'h0000_0000)
      |=> s_swt_set ##1 s_swt_gone)
      else $error("software trigger did not self clear");

   chk_swt_event: assert property (|(swt_r & mask_r) |=> |(pend_r & $past(swt_r & mask_r)))
      else $error("software trigger gave no pending flag");

   chk_no_edge_quiet: assert property
      ((edges.rise == 32'h0000_0000 && edges.fall == 32'h0000_0000 && swt_r == 32'h0000_0000)
      |=> (pend_new == 32'h0000_0000))
      else $error("flag set without an edge");

   chk_irq_level: assert property (irq == |(pend_r & mask_r))
      else $error("interrupt output disagrees with flags");

   // Rising and falling edges are judged apart, so turning one direction off
   // must silence it even while the other stays on.
   chk_fall_off: assert property
      (((edges.fall & fall_en_r) == 32'h0000_0000 && edges.rise == 32'h0000_0000 && swt_r == 32'h0000_0000)
      |=> (pend_new == 32'h0000_0000))
      else $error("disabled falling edge set a flag");

   chk_rise_off: assert property
      (((edges.rise & rise_en_r) == 32'h0000_0000 && edges.fall == 32'h0000_0000 && swt_r == 32'h0000_0000)
      |=> (pend_new == 32'h0000_0000))
      else $error("disabled rising edge set a flag");

   chk_rise_write_blk: assert property
      (wr_rise |=> ((pend_r & $past(edges.rise & ~swt_r & ~pend_r)) == 32'h0000_0000))
      else $error("rising edge during select write set a flag");

   chk_set_beats_clr: assert property
      (|(trig & mask_r) |=> ((pend_r & $past(trig & mask_r)) == $past(trig & mask_r)))
      else $error("unmasked trigger lost its flag");

   chk_pend_w1c: assert property
      ((wr_pend && (trig & mask_r) == 32'h0000_0000) |=> ((pend_r & $past(pend_clr)) == 32'h0000_0000))
      else $error("written one did not clear a flag");

   // A flag may only fall through an acknowledge; nothing else clears it.
   chk_pend_keep: assert property
      ((pend_prev_r & ~pend_r & ~$past(pend_clr)) == 32'h0000_0000)
      else $error("flag dropped without an acknowledge");

   chk_swt_zero_noop: assert property
      ((wr_swt && new_swt == 32'h0000_0000) |=> (swt_r == 32'h0000_0000))
      else $error("zero write raised a software trigger");

   chk_fall_rsvd_read: assert property
      ((ar_fire && rd_off == `ETSEL_OFF_FALL) |=> ((rdata & ~`ETSEL_LINE_MASK) == 32'h0000_0000))
      else $error("reserved falling select bit read as one");

   // Offsets outside the map answer with an error response.
   chk_wr_unmapped: assert property
      ((wr_go && !mapped(wr_off)) |=> (bvalid && bresp == `ETSEL_RESP_SLVERR))
      else $error("unmapped write not refused");

   chk_rd_unmapped: assert property
      ((ar_fire && !mapped(rd_off)) |=> (rvalid && rresp == `ETSEL_RESP_SLVERR && rdata == 32'h0000_0000))
      else $error("unmapped read not refused");

   chk_bvalid_hold: assert property
      ((bvalid && !bready) |=> (bvalid && $stable(bresp)))
      else $error("write response dropped before it was taken");

   chk_rvalid_hold: assert property
      ((rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
      else $error("read response dropped before it was taken");
endmodule

// ==== src/etsel_defines.svh ====
// Register offsets, field layout and reset values for the edge trigger selector.
`ifndef ETSEL_DEFINES_SVH
`define ETSEL_DEFINES_SVH
`define ETSEL_NLINES 19
`define ETSEL_AW 8
`define ETSEL_OFF_RISE 8'h00
`define ETSEL_OFF_FALL 8'h04
`define ETSEL_OFF_SWT 8'h08
`define ETSEL_OFF_MASK 8'h0C
`define ETSEL_OFF_PEND 8'h10
`define ETSEL_LINE_MASK 32'h0006_00FF
`define ETSEL_RST_VAL 32'h0000_0000
`define ETSEL_RESP_OKAY 2'h0
`define ETSEL_RESP_SLVERR 2'h2
`endif

// ==== src/etsel_pkg.sv ====
// Types shared by the edge trigger selector modules.
package etsel_pkg;
   typedef logic [31:0] etsel_word_t;
   typedef logic [18:0] etsel_pins_t;
   typedef struct packed {
      etsel_word_t rise;
      etsel_word_t fall;
   } etsel_edge_t;
   typedef struct packed {
      logic [7:0] addr;
      etsel_word_t data;
      logic [3:0] strb;
   } etsel_wreq_t;
endpackage

// ==== src/etsel_sync.sv ====
// Three-stage line synchroniser with rising and falling edge pulse detection.
`timescale 1ns/1ps
`include "etsel_defines.svh"
module etsel_sync
   import etsel_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire etsel_pins_t line_in,
   output etsel_edge_t edges
);
   etsel_word_t s1_r, s2_r, s3_r, lvl_r, rise_r, fall_r;
   etsel_word_t s1_nxt, lvl_nxt, rise_nxt, fall_nxt;
   etsel_word_t stable;

   // Only the agreement of stages two and three moves the held level, so the
   // first stage stays private to the second.
   always_comb begin
      s1_nxt = {13'h0000, line_in} & `ETSEL_LINE_MASK;
      stable = ~(s2_r ^ s3_r);
      lvl_nxt = (stable & s3_r) | (~stable & lvl_r);
      rise_nxt = stable & s3_r & ~lvl_r;
      fall_nxt = stable & ~s3_r & lvl_r;
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= `ETSEL_RST_VAL;
         s2_r <= `ETSEL_RST_VAL;
         s3_r <= `ETSEL_RST_VAL;
         lvl_r <= `ETSEL_RST_VAL;
         rise_r <= `ETSEL_RST_VAL;
         fall_r <= `ETSEL_RST_VAL;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s1_r;
         s3_r <= s2_r;
         lvl_r <= lvl_nxt;
         rise_r <= rise_nxt;
         fall_r <= fall_nxt;
      end
   end

   assign edges = '{rise: rise_r, fall: fall_r};

   chk_edge_one_cycle: assert property (@(posedge aclk) disable iff (!aresetn)
      ((edges.rise | edges.fall) & $past(edges.rise | edges.fall)) == 32'h0000_0000)
      else $error("edge pulse lasted more than one cycle");

   chk_edge_from_level: assert property (@(posedge aclk) disable iff (!aresetn)
      (edges.rise != 32'h0000_0000) |-> ((edges.rise & ~lvl_r) == 32'h0000_0000))
      else $error("rising pulse without a level change");
endmodule

// ==== testbench/etsel_line_src.sv ====
// Glitch-free model of the sources that drive the external trigger lines.
`timescale 1ns/1ps
module etsel_line_src
   import etsel_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire etsel_pins_t want,
   output etsel_pins_t line_out
);
   // Levels change only just after an edge, so no runt pulse can reach a line.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         line_out <= '0;
      end else begin
         line_out <= want;
      end
   end
endmodule

// ==== testbench/test_edge_trigger_select.sv ====
// Self-checking bench for the edge trigger selector and its register slave.
`timescale 1ns/1ps
`include "etsel_defines.svh"
module test_edge_trigger_select
   import etsel_pkg::*;
;
   logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic [7:0] awaddr = '0, araddr = '0;
   logic [3:0] wstrb = '0, st = 4'hf;
   logic awready, wready, bvalid, arready, rvalid, irq;
   logic [1:0] bresp, rresp, r;
   etsel_word_t wdata = '0, rdata, d, e, rs, fs, mk;
   etsel_word_t s = 32'h0000_5d34;
   etsel_word_t lm = `ETSEL_LINE_MASK;
   etsel_pins_t want = '0, ext_line;
   int n_mismatch = 0, total_checks = 0, hit = 0, miss = 0;
   always #2 aclk = ~aclk;
   etsel_line_src src_u(.aclk(aclk), .aresetn(aresetn), .want(want), .line_out(ext_line));
   etsel_top dut_u(.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
      .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0),
      .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp), .ext_line(ext_line), .irq(irq));
   function automatic etsel_word_t lfsr(input etsel_word_t v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   function automatic etsel_word_t exp_pend(input etsel_word_t rise, fall, input etsel_pins_t o, n);
      return ((32'(~o & n) & rise) | (32'(o & ~n) & fall)) & `ETSEL_LINE_MASK;
   endfunction
   task automatic chk(input etsel_word_t got, input etsel_word_t exp);
      total_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input etsel_word_t v);
      logic aw;
      logic w;
      aw = 1;
      w = 1;
      @(posedge aclk);
      awvalid <= 1;
      wvalid <= 1;
      awaddr <= a;
      wdata <= v;
      wstrb <= st;
      bready <= 1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && awready) begin
            aw = 0;
            awvalid <= 0;
         end
         if (w && wready) begin
            w = 0;
            wvalid <= 0;
         end
      end
      do @(posedge aclk); while (!bvalid);
      bready <= 0;
      r = bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      arvalid <= 1;
      araddr <= a;
      rready <= 1;
      do @(posedge aclk); while (!arready);
      arvalid <= 0;
      do @(posedge aclk); while (!rvalid);
      rready <= 0;
      d = rdata;
      r = rresp;
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      repeat (20000) @(posedge aclk);
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      for (int i = 0; i < 5; i++) begin
         rd(8'(4 * i));
         chk(d, `ETSEL_RST_VAL);
      end
      rd(8'h14);
      chk(d, 32'h0000_0000);
      chk(32'(r), 32'h0000_0002);
      wr(8'h14, '1);
      chk(32'(r), 32'h0000_0002);
      // Only the third byte lane is enabled, so only lines 17 and 18 change.
      st = 4'h4;
      wr(`ETSEL_OFF_RISE, '1);
      st = 4'hf;
      chk(32'(r), 32'h0000_0000);
      rd(`ETSEL_OFF_RISE);
      chk(d, 32'h0006_0000);
      // Every implemented line is fired once from software.
      wr(`ETSEL_OFF_MASK, '1);
      chk(32'(r), 32'h0000_0000);
      wr(`ETSEL_OFF_SWT, 32'h0000_0000);
      rd(`ETSEL_OFF_PEND);
      chk(d, 32'h0000_0000);
      for (int i = 0; i < 19; i++) begin
         if (lm[i]) begin
            // The read is issued so that it lands in the one cycle the bit stands.
            fork
               wr(`ETSEL_OFF_SWT, 32'h0000_0001 << i);
               begin
                  @(posedge aclk);
                  rd(`ETSEL_OFF_SWT);
               end
            join
            chk(d, 32'h0000_0001 << i);
            rd(`ETSEL_OFF_SWT);
            chk(d, 32'h0000_0000);
            rd(`ETSEL_OFF_PEND);
            chk(d, 32'h0000_0001 << i);
            chk(32'(irq), 32'h0000_0001);
            wr(`ETSEL_OFF_PEND, '1);
            chk(32'(irq), 32'h0000_0000);
         end
      end
      for (int k = 0; k < 12; k++) begin
         s = lfsr(s);
         rs = s;
         wr(`ETSEL_OFF_RISE, rs);
         rd(`ETSEL_OFF_RISE);
         chk(d, rs & lm);
         s = lfsr(lfsr(s));
         fs = s;
         wr(`ETSEL_OFF_FALL, fs);
         rd(`ETSEL_OFF_FALL);
         chk(d, fs & lm);
         s = lfsr(lfsr(s));
         mk = s;
         wr(`ETSEL_OFF_MASK, mk);
         wr(`ETSEL_OFF_PEND, '1);
         rd(`ETSEL_OFF_PEND);
         chk(d, 32'h0000_0000);
         s = lfsr(lfsr(s));
         e = exp_pend(rs, fs, want, s[18:0]) & mk;
         want <= s[18:0];
         repeat (10) @(posedge aclk);
         rd(`ETSEL_OFF_PEND);
         chk(d, e);
         chk(32'(irq), 32'(e != 0));
      end
      // The select write is slid across the arrival of a falling edge; one slot must collide.
      wr(`ETSEL_OFF_RISE, '0);
      wr(`ETSEL_OFF_FALL, lm);
      wr(`ETSEL_OFF_MASK, '1);
      for (int k = 0; k < 8; k++) begin
         want <= '1;
         repeat (8) @(posedge aclk);
         wr(`ETSEL_OFF_PEND, '1);
         want <= '0;
         repeat (k) @(posedge aclk);
         wr(`ETSEL_OFF_FALL, lm);
         repeat (8) @(posedge aclk);
         rd(`ETSEL_OFF_PEND);
         if (d === lm) begin
            hit++;
         end else if (d === 32'h0000_0000) begin
            miss++;
         end
      end
      chk(32'(miss == 1 && hit == 7), 32'h0000_0001);
      report_and_stop();
   end
endmodule
